/* File: lhcp_pkg.sv */
package lhcp_pkg;
  localparam int         TEXT_DEPTH    = 80;
  localparam logic [7:0] BLANK_CODE    = 8'h20;
  localparam logic [5:0] SLAVE_ADDR_HI = 6'h1D;
  localparam int         CLK_MHZ       = 125;
  localparam int         EXEC_TIME_US  = 40;
  localparam int         EXEC_CYC_DEF  = EXEC_TIME_US * CLK_MHZ;
  localparam logic [6:0] AC_ZERO       = 7'h00;
  localparam logic [6:0] AC_LAST       = 7'h4F;
  localparam logic [7:0] DEPTH_8       = 8'h50;
  localparam logic [3:0] ACK_BIT       = 4'h8;
  localparam int         CTRL_CONT_BIT = 7;
  localparam int         CTRL_RS_BIT   = 6;
  localparam int         ADDR_RW_BIT   = 0;
  localparam int         FSET_DL_BIT   = 4;
  localparam int         ENTRY_ID_BIT  = 1;
  localparam int         ENTRY_S_BIT   = 0;
  localparam int         DCTL_D_BIT    = 2;
  localparam int         DCTL_C_BIT    = 1;
  localparam int         DCTL_B_BIT    = 0;
  localparam int         SHIFT_SC_BIT  = 3;
  localparam int         SHIFT_RL_BIT  = 2;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_ADDR = 3'b001,
    PH_CTRL = 3'b011,
    PH_DATA = 3'b010,
    PH_READ = 3'b110,
    PH_IGN  = 3'b111
  } lhcp_phase_t;
endpackage : lhcp_pkg

/* File: lhcp_top.sv */
`timescale 1ns/1ps
// Operation
// - Acknowledge own write address by pulling data line low in ack clock.
// - Control byte carries continuation and select bits; select applies onward.
// - Serial instruction byte executes on its acknowledge clock pulse.
// - Text memory starts blank-coded, so display shows blank everywhere.
// - Return home zeroes address counter and display shift, keeps memory.
// - Return home leaves the read staging latch untouched.
// - Read address ack copies staging latch (select set), else busy flag and counter, into serial shift register.
// - With select set, read bytes return text memory content.
// - Read byte is eight clocks, loaded content shifted out MSB first.
// - Master ack loads next address content and advances address counter.
// - Master no-ack: no load, no latch update, no counter or cursor move.
// - Single nibble function set enters 4-bit mode; upper nibble first.
module lhcp_top
  import lhcp_pkg::*;
#(
  parameter int EXEC_CYC = EXEC_CYC_DEF
) (
  input  wire logic       sys_clk,         // Core clock
  input  wire logic       rst_n,           // Sync reset, active low
  input  wire logic       scl_i,           // Serial clock pin
  input  wire logic       sda_i,           // Serial data pin level
  output      logic       sda_o,           // Serial data drive value
  output      logic       sda_oe,          // Serial data drive enable
  input  wire logic       address_lsb_pin, // Slave address strap
  input  wire logic       par_e_clk,       // Parallel bus strobe clock
  input  wire logic       par_rs,          // Parallel register select
  input  wire logic       par_rw,          // Parallel read, high
  input  wire logic [7:0] par_db,          // Parallel data bus
  input  wire logic [6:0] disp_addr,       // Display fetch position
  output      logic [7:0] disp_char,       // Character at position
  output      logic       disp_on,         // Display enabled
  output      logic       cursor_on,       // Cursor enabled
  output      logic       blink_on,        // Cursor blink enabled
  output      logic [6:0] addr_count,      // Address counter
  output      logic [6:0] disp_shift,      // Display shift amount
  output      logic       four_bit_mode,   // Parallel 4-bit mode
  output      logic       busy_indicator   // Instruction executing
);
  function automatic logic [6:0] lhcp_step(input logic [6:0] a,
                                           input logic       up);
    if (up) return (a == AC_LAST) ? AC_ZERO : a + 7'h01;
    return (a == AC_ZERO) ? AC_LAST : a - 7'h01;
  endfunction : lhcp_step

  // Pin and strobe-domain synchronisers and edge history
  logic        scl_m_r, scl_s_r, scl_d_r;
  logic        sda_m_r, sda_s_r, sda_d_r;
  logic        sa0_m_r, sa0_s_r;
  logic        ptog_m_r, ptog_s_r, ptog_d_r;
  logic        pmode_m_r, pmode_s_r;
  // Serial engine
  lhcp_phase_t phase_r, phase_nxt;
  logic [3:0]  bitcnt_r, bitcnt_nxt;
  logic [7:0]  rx_r, rx_nxt;
  logic [7:0]  tx_r, tx_nxt;
  logic        ack_drv_r, ack_nxt;
  logic        rd_act_r, rdact_nxt;
  logic        cont_r, cont_nxt;
  logic        rs_r, rs_nxt;
  logic        i2c_exec, i2c_rd;
  // Core state
  logic [7:0]  text_r [TEXT_DEPTH];
  logic [6:0]  ac_r, shift_r;
  logic [7:0]  latch_r;
  logic        id_r, sh_en_r, disp_on_r, cur_r, blink_r;
  logic [12:0] busy_r;
  logic        par_pend_r;
  logic [8:0]  pword_r;
  logic [7:0]  disp_char_r;
  logic        lrst_m_r, lrst_s_r;
  logic        four_bit_r, hi_pend_r;
  logic [3:0]  hi_nib_r;
  logic [7:0]  lword_r;
  logic        lrs_r, ltog_r;

  always_ff @(posedge sys_clk) begin
    scl_m_r   <= scl_i;
    scl_s_r   <= scl_m_r;
    scl_d_r   <= scl_s_r;
    sda_m_r   <= sda_i;
    sda_s_r   <= sda_m_r;
    sda_d_r   <= sda_s_r;
    sa0_m_r   <= address_lsb_pin;
    sa0_s_r   <= sa0_m_r;
    pmode_m_r <= four_bit_r;
    pmode_s_r <= pmode_m_r;
    ptog_m_r  <= ltog_r;
    ptog_s_r  <= ptog_m_r;
    ptog_d_r  <= ptog_s_r;
  end

  wire scl_rise  = scl_s_r & ~scl_d_r;
  wire scl_fall  = ~scl_s_r & scl_d_r;
  wire scl_high  = scl_s_r & scl_d_r;
  wire bus_start = scl_high & sda_d_r & ~sda_s_r;
  wire bus_stop  = scl_high & ~sda_d_r & sda_s_r;
  wire at_ack    = (bitcnt_r == ACK_BIT);
  wire addr_hit  = (rx_r[7:1] == {SLAVE_ADDR_HI, sa0_s_r});
  wire busy      = (busy_r != 13'h0000);
  wire [7:0] rd_word = rs_r ? latch_r : {busy, ac_r};

  always_comb begin
    phase_nxt  = phase_r;
    bitcnt_nxt = bitcnt_r;
    rx_nxt     = rx_r;
    tx_nxt     = tx_r;
    ack_nxt    = ack_drv_r;
    rdact_nxt  = rd_act_r;
    cont_nxt   = cont_r;
    rs_nxt     = rs_r;
    i2c_exec   = 1'b0;
    i2c_rd     = 1'b0;
    if (bus_start) begin
      phase_nxt  = PH_ADDR;
      bitcnt_nxt = 4'h0;
      ack_nxt    = 1'b0;
      rdact_nxt  = 1'b0;
    end else if (bus_stop) begin
      phase_nxt = PH_IDLE;
      ack_nxt   = 1'b0;
      rdact_nxt = 1'b0;
    end else if (scl_rise && phase_r != PH_IDLE) begin
      bitcnt_nxt = at_ack ? 4'h0 : bitcnt_r + 4'h1;
      if (!at_ack) begin
        rx_nxt = {rx_r[6:0], sda_s_r};
      end else begin
        unique case (phase_r)
          PH_ADDR: begin
            if (!addr_hit) phase_nxt = PH_IGN;
            else phase_nxt = rx_r[ADDR_RW_BIT] ? PH_READ : PH_CTRL;
          end
          PH_CTRL: begin
            cont_nxt  = rx_r[CTRL_CONT_BIT];
            rs_nxt    = rx_r[CTRL_RS_BIT];
            phase_nxt = PH_DATA;
          end
          PH_DATA: begin
            i2c_exec = 1'b1;
            if (cont_r) phase_nxt = PH_CTRL;
          end
          PH_READ: begin
            if (!ack_drv_r) begin
              if (sda_s_r) phase_nxt = PH_IGN;
              else i2c_rd = 1'b1;
            end
          end
          PH_IDLE, PH_IGN: ;
        endcase
      end
    end else if (scl_fall && phase_r != PH_IDLE) begin
      if (at_ack) begin
        rdact_nxt = 1'b0;
        if (phase_r == PH_ADDR) ack_nxt = addr_hit;
        else if (phase_r == PH_CTRL || phase_r == PH_DATA) ack_nxt = 1'b1;
      end else if (bitcnt_r == 4'h0) begin
        ack_nxt = 1'b0;
        if (phase_r == PH_READ) begin
          tx_nxt    = rd_word;
          rdact_nxt = 1'b1;
        end
      end else if (rd_act_r) begin
        tx_nxt = {tx_r[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phase_r   <= PH_IDLE;
      bitcnt_r  <= 4'h0;
      rx_r      <= 8'h00;
      tx_r      <= 8'h00;
      ack_drv_r <= 1'b0;
      rd_act_r  <= 1'b0;
      cont_r    <= 1'b0;
      rs_r      <= 1'b0;
    end else begin
      phase_r   <= phase_nxt;
      bitcnt_r  <= bitcnt_nxt;
      rx_r      <= rx_nxt;
      tx_r      <= tx_nxt;
      ack_drv_r <= ack_nxt;
      rd_act_r  <= rdact_nxt;
      cont_r    <= cont_nxt;
      rs_r      <= rs_nxt;
    end
  end

  assign sda_o  = 1'b0;
  assign sda_oe = ack_drv_r | (rd_act_r & ~tx_r[7]);

  // Parallel words queue behind a serial one in the same cycle
  wire       par_edge  = ptog_s_r ^ ptog_d_r;
  wire       par_take  = par_pend_r & ~i2c_exec;
  wire       exec_v    = i2c_exec | par_take;
  wire       exec_rs   = i2c_exec ? rs_r : pword_r[8];
  wire [7:0] exec_byte = i2c_exec ? rx_r : pword_r[7:0];
  wire       instr     = exec_v & ~exec_rs;
  wire       do_write  = exec_v & exec_rs;
  wire       do_clear  = instr & (exec_byte == 8'h01);
  wire       do_home   = instr & (exec_byte[7:1] == 7'h01);
  wire       do_entry  = instr & (exec_byte[7:2] == 6'h01);
  wire       do_dctl   = instr & (exec_byte[7:3] == 5'h01);
  wire       do_shift  = instr & (exec_byte[7:4] == 4'h1);
  wire       do_setdd  = instr & exec_byte[7];
  wire [6:0] dd_addr   = (exec_byte[6:0] > AC_LAST) ? AC_ZERO : exec_byte[6:0];
  wire [6:0] ac_up     = lhcp_step(ac_r, id_r);
  wire       sh_dir    = exec_byte[SHIFT_RL_BIT];
  wire       sh_move   = do_shift & exec_byte[SHIFT_SC_BIT];
  wire [7:0] pos_sum   = {1'b0, disp_addr} + {1'b0, shift_r};
  wire [7:0] pos_wrap  = (pos_sum >= DEPTH_8) ? pos_sum - DEPTH_8 : pos_sum;
  wire [6:0] disp_pos  = pos_wrap[6:0];

  genvar gi;
  generate
    for (gi = 0; gi < TEXT_DEPTH; gi++) begin : g_text
      always_ff @(posedge sys_clk) begin
        if (!rst_n || do_clear) text_r[gi] <= BLANK_CODE;
        else if (do_write && ac_r == 7'(gi)) text_r[gi] <= exec_byte;
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (!rst_n || do_clear || do_home) ac_r <= AC_ZERO;
    else if (do_setdd) ac_r <= dd_addr;
    else if (do_write || i2c_rd) ac_r <= ac_up;
    else if (do_shift && !exec_byte[SHIFT_SC_BIT]) ac_r <= lhcp_step(ac_r, sh_dir);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || do_clear || do_home) shift_r <= AC_ZERO;
    else if (sh_move) shift_r <= lhcp_step(shift_r, ~sh_dir);
    else if (do_write && sh_en_r) shift_r <= lhcp_step(shift_r, id_r);
  end

  // Latch refreshes only on set-address and read
  always_ff @(posedge sys_clk) begin
    if (!rst_n) latch_r <= BLANK_CODE;
    else if (do_setdd) latch_r <= text_r[dd_addr];
    else if (i2c_rd) latch_r <= text_r[ac_up];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      id_r      <= 1'b1;
      sh_en_r   <= 1'b0;
      disp_on_r <= 1'b0;
      cur_r     <= 1'b0;
      blink_r   <= 1'b0;
    end else if (do_entry) begin
      id_r    <= exec_byte[ENTRY_ID_BIT];
      sh_en_r <= exec_byte[ENTRY_S_BIT];
    end else if (do_dctl) begin
      disp_on_r <= exec_byte[DCTL_D_BIT];
      cur_r     <= exec_byte[DCTL_C_BIT];
      blink_r   <= exec_byte[DCTL_B_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) busy_r <= 13'h0000;
    else if (exec_v) busy_r <= 13'(EXEC_CYC);
    else if (busy) busy_r <= busy_r - 13'h0001;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) par_pend_r <= 1'b0;
    else if (par_edge) par_pend_r <= 1'b1;
    else if (par_take) par_pend_r <= 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) pword_r <= 9'h000;
    else if (par_edge) pword_r <= {lrs_r, lword_r};
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) disp_char_r <= BLANK_CODE;
    else disp_char_r <= text_r[disp_pos];
  end

  assign disp_char      = disp_char_r;
  assign disp_on        = disp_on_r;
  assign cursor_on      = cur_r;
  assign blink_on       = blink_r;
  assign addr_count     = ac_r;
  assign disp_shift     = shift_r;
  assign four_bit_mode  = pmode_s_r;
  assign busy_indicator = busy;

  // Parallel bus side, strobe clock domain

  wire       l_wr   = ~par_rw;
  wire       l_half = four_bit_r & ~hi_pend_r;
  wire [7:0] l_byte = four_bit_r ? {hi_nib_r, par_db[7:4]} : par_db;
  wire       l_fset = ~par_rs & (l_byte[7:5] == 3'b001);

  always_ff @(posedge par_e_clk) begin
    lrst_m_r  <= rst_n;
    lrst_s_r  <= lrst_m_r;
  end

  always_ff @(posedge par_e_clk) begin
    if (!lrst_s_r) begin
      four_bit_r <= 1'b0;
      hi_pend_r  <= 1'b0;
      hi_nib_r   <= 4'h0;
      lword_r    <= 8'h00;
      lrs_r      <= 1'b0;
      ltog_r     <= 1'b0;
    end else if (l_wr && l_half) begin
      hi_nib_r  <= par_db[7:4];
      hi_pend_r <= 1'b1;
    end else if (l_wr) begin
      lword_r   <= l_byte;
      lrs_r     <= par_rs;
      ltog_r    <= ~ltog_r;
      hi_pend_r <= 1'b0;
      if (l_fset) four_bit_r <= ~l_byte[FSET_DL_BIT];
    end
  end
endmodule : lhcp_top

/* File: lhcp_host.sv */
`timescale 1ns/1ps
module lhcp_host (
  input  wire logic sys_clk, // Core clock
  input  wire logic sda_oe,  // Device pulls data low
  output      logic scl,     // Serial clock
  output      logic sda      // Resolved data line
);
  logic host_low = 1'b0;
  initial scl = 1'b1;
  // Pull-up wins when nobody pulls low
  assign sda = !(host_low || sda_oe);
  task automatic tick;
    repeat (6) @(negedge sys_clk);
  endtask : tick
  task automatic bit_io(input logic b, output logic got);
    host_low = !b;
    tick();
    scl = 1'b1;
    tick();
    got = sda;
    scl = 1'b0;
  endtask : bit_io
  task automatic start;
    host_low = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    host_low = 1'b1;
    tick();
    scl = 1'b0;
  endtask : start
  task automatic stop;
    host_low = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    host_low = 1'b0;
    tick();
  endtask : stop
  task automatic xfer(input logic [7:0] tx, input logic mack,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(!mack, ack);
  endtask : xfer
endmodule : lhcp_host

/* File: lhcp_asserts.sv */
`timescale 1ns/1ps
module lhcp_asserts
  import lhcp_pkg::*;
#(
  parameter int EXEC_CYC = 20
) (
  input wire logic       sys_clk,       // Core clock
  input wire logic       rst_n,         // Sync reset
  input wire logic       scl_i,         // Serial clock
  input wire logic       sda_o,         // Data value
  input wire logic       sda_oe,        // Data enable
  input wire logic       disp_on,       // Display on
  input wire logic       cursor_on,     // Cursor on
  input wire logic       blink_on,      // Blink on
  input wire logic [7:0] disp_char,     // Fetched char
  input wire logic [6:0] addr_count,    // Address counter
  input wire logic [6:0] disp_shift,    // Shift amount
  input wire logic       busy_indicator // Busy
);
  logic [15:0] busy_cnt_r;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge sys_clk)
    busy_cnt_r <= (rst_n && busy_indicator) ?
                  busy_cnt_r + 16'h0001 : 16'h0000;
  reset_state_a: assert property ($rose(rst_n) |->
    addr_count == AC_ZERO && !disp_on && !busy_indicator &&
    disp_char == BLANK_CODE) else $error("state not cleared by reset");
  busy_len_a: assert property ($fell(busy_indicator) |->
    busy_cnt_r + 1 >= EXEC_CYC && busy_cnt_r <= EXEC_CYC + 1)
    else $error("busy length wrong");
  busy_cap_a: assert property (busy_cnt_r <= EXEC_CYC + 1)
    else $error("busy held too long");
  sda_low_a: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  ack_clk_a: assert property ($rose(sda_oe) |-> !scl_i)
    else $error("data drive began with clock high");
  sda_steady_a: assert property (scl_i [*6] |-> $stable(sda_oe))
    else $error("data drive moved with clock high");
  disp_cause_a: assert property ($changed({disp_on, cursor_on,
    blink_on, disp_shift}) |-> ##[0:1] busy_indicator)
    else $error("display state changed without execution");
  addr_range_a: assert property (addr_count <= AC_LAST)
    else $error("address counter out of range");
endmodule : lhcp_asserts
bind lhcp_top lhcp_asserts #(.EXEC_CYC(EXEC_CYC)) i_lhcp_asserts (
  .sys_clk, .rst_n, .scl_i, .sda_o, .sda_oe, .disp_on, .cursor_on,
  .blink_on, .disp_char, .addr_count, .disp_shift, .busy_indicator);

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top
  import lhcp_pkg::*;
;
  localparam int         EXEC   = 20;
  localparam int         GAP    = EXEC + 10;
  localparam logic [7:0] ADDR_W = {SLAVE_ADDR_HI, 2'b00};
  localparam logic [7:0] ADDR_R = {SLAVE_ADDR_HI, 2'b01};
  logic        sys_clk, rst_n, scl_i, sda_i, sda_o, sda_oe, ack;
  logic        address_lsb_pin, par_e_clk, par_rs, par_rw;
  logic [7:0]  par_db, disp_char, rx;
  logic [6:0]  disp_addr, addr_count, disp_shift;
  logic        disp_on, cursor_on, blink_on, four_bit_mode, busy_indicator;
  int          err_count, checks;
  logic [10:0] rows [4] = '{{8'h0E, 3'b110}, {8'h0F, 3'b111},
                            {8'h0D, 3'b101}, {8'h08, 3'b000}};
  lhcp_top #(.EXEC_CYC(EXEC)) i_lhcp_top (
    .sys_clk, .rst_n, .scl_i, .sda_i, .sda_o, .sda_oe, .address_lsb_pin,
    .par_e_clk, .par_rs, .par_rw, .par_db, .disp_addr, .disp_char,
    .disp_on, .cursor_on, .blink_on, .addr_count, .disp_shift,
    .four_bit_mode, .busy_indicator);
  lhcp_host i_lhcp_host (.sys_clk, .sda_oe, .scl(scl_i), .sda(sda_i));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic close_out;
    if (err_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  initial begin
    #400000;
    err_count++;
    close_out();
  end
  task automatic check(input string what, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  // One strobe clock pulse; do_reset uses it with par_rw high to carry reset into the strobe domain
  task automatic pulse;
    @(negedge sys_clk);
    #3 par_e_clk = 1'b1;
    #3 par_e_clk = 1'b0;
  endtask : pulse
  task automatic do_reset;
    @(negedge sys_clk);
    rst_n = 1'b0;
    par_rw = 1'b1;
    repeat (10) pulse();
    @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) pulse();
  endtask : do_reset
  task automatic send(input logic [7:0] b);
    i_lhcp_host.xfer(b, 1'b0, rx, ack);
    check("ack", 8'(ack), 8'h00);
  endtask : send
  task automatic rd(input logic mack, input logic [7:0] exp);
    i_lhcp_host.xfer(8'hFF, mack, rx, ack);
    check("rdata", rx, exp);
  endtask : rd
  task automatic cmd(input logic [7:0] ctl, input logic [7:0] b);
    i_lhcp_host.start();
    send(ADDR_W);
    send(ctl);
    send(b);
    i_lhcp_host.stop();
    repeat (GAP) @(negedge sys_clk);
  endtask : cmd
  // Init waits shortened to one execution gap
  task automatic pwr(input logic rs, input logic [7:0] db);
    par_rs = rs;
    par_db = db;
    par_rw = 1'b0;
    #3 par_e_clk = 1'b1;
    #3 par_e_clk = 1'b0;
    repeat (GAP) @(negedge sys_clk);
  endtask : pwr
  task automatic nib(input logic rs, input logic [7:0] b);
    pwr(rs, {b[7:4], 4'h0});
    pwr(rs, {b[3:0], 4'h0});
  endtask : nib
  task automatic peek(input logic [6:0] a, input logic [7:0] exp);
    disp_addr = a;
    repeat (2) @(negedge sys_clk);
    check("char", disp_char, exp);
  endtask : peek
  initial begin
    {rst_n, par_e_clk, par_rs, par_db, address_lsb_pin} = '0;
    par_rw = 1'b1;
    disp_addr = 7'h00;
    do_reset();
    foreach (rows[i]) begin
      cmd(8'h00, rows[i][10:3]);
      check("dctl", 8'({disp_on, cursor_on, blink_on}), 8'(rows[i][2:0]));
    end
    peek(7'h05, BLANK_CODE);
    i_lhcp_host.start();
    i_lhcp_host.xfer(ADDR_W ^ 8'h02, 1'b0, rx, ack);
    check("nack", 8'(ack), 8'h01);
    i_lhcp_host.stop();
    i_lhcp_host.start();
    send(ADDR_W);
    send(8'hC0);
    send("P");
    send(8'h40);
    send("H");
    send("I");
    cmd(8'h00, 8'h18);
    check("shift", 8'(disp_shift), 8'h01);
    peek(7'h00, "H");
    cmd(8'h80, 8'h02);
    check("ac", 8'(addr_count), 8'h00);
    check("shift", 8'(disp_shift), 8'h00);
    peek(7'h01, "H");
    i_lhcp_host.start();
    send(ADDR_W);
    send(8'h40);
    i_lhcp_host.stop();
    i_lhcp_host.start();
    send(ADDR_R);
    rd(1'b1, BLANK_CODE);
    rd(1'b1, "H");
    rd(1'b0, "I");
    i_lhcp_host.stop();
    check("ac", 8'(addr_count), 8'h02);
    cmd(8'h00, 8'h81);
    i_lhcp_host.start();
    send(ADDR_R);
    rd(1'b0, 8'h01);
    i_lhcp_host.start();
    send(ADDR_W);
    send(8'h40);
    i_lhcp_host.start();
    send(ADDR_R);
    rd(1'b0, "H");
    i_lhcp_host.stop();
    check("ac", 8'(addr_count), 8'h01);
    cmd(8'h00, 8'h82);
    repeat (3) pwr(1'b0, 8'h30);
    pwr(1'b0, 8'h20);
    check("four", 8'(four_bit_mode), 8'h01);
    pwr(1'b0, 8'h00);
    pwr(1'b0, 8'hC0);
    check("dctl", 8'({disp_on, cursor_on, blink_on}), 8'h04);
    pwr(1'b1, 8'h40);
    pwr(1'b1, 8'hD0);
    peek(7'h02, "M");
    peek(7'h00, "P");
    nib(1'b0, 8'h20);
    nib(1'b0, 8'h08);
    nib(1'b0, 8'h01);
    nib(1'b0, 8'h06);
    check("dctl", 8'({disp_on, cursor_on, blink_on}), 8'h00);
    check("ac", 8'(addr_count), 8'h00);
    peek(7'h02, BLANK_CODE);
    do_reset();
    check("rst", {four_bit_mode, addr_count}, 8'h00);
    check("rst_on", 8'(disp_on), 8'h00);
    peek(7'h02, BLANK_CODE);
    close_out();
  end
endmodule : tb_top
